// ===== mem_cfg_pkg.sv
package mem_cfg_pkg;

  // ==========================================================
  // bus map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

  // ==========================================================
  // global_memory_config field positions
  localparam int INTERVAL_LSB = 24;
  localparam int INTERVAL_W = 8;
  localparam int REFRESH_ON_BIT = 23;
  localparam int REFRESH_LENGTH_LSB = 21;
  localparam int PAGE_SPAN_LSB = 18;
  localparam int DRAM_WIDTH_LSB = 16;
  localparam int PRECHARGE_EXT_BIT = 15;
  localparam int PRECHARGE_NATIVE_BIT = 14;
  localparam int EXT_SYNC_BIT = 13;
  localparam int EXT_SRAM_WAIT_BIT = 12;
  localparam int ODD_PARITY_BIT = 11;
  localparam int PARITY_BERR_BIT = 10;
  localparam int LATE_STROBE_BIT = 9;
  localparam int NO_CPU_SPACE_BIT = 8;
  localparam int PAGE_WRITE_DELAY_BIT = 7;
  localparam int SRAM_WRITE_DELAY_BIT = 6;
  localparam int GLOBAL_AMUX_BIT = 5;

  // reserved bits 4..0 never store and read as zero
  localparam logic [31:0] CFG_WRITE_MASK = 32'hffff_ffe0;
  localparam logic [31:0] CFG_RESET = 32'h0000_1200;

  // ==========================================================
  // status register layout
  localparam int STAT_PENDING_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam logic [2:0] PENDING_MAX = 3'h7;

  // ==========================================================
  // refresh timing
  localparam logic [3:0] PRESCALE_LAST = 4'hf;  // system clock / 16
  localparam logic [1:0] REF_LEN_4 = 2'h0;
  localparam logic [1:0] REF_LEN_6 = 2'h1;
  localparam logic [1:0] REF_LEN_7 = 2'h2;
  localparam logic [3:0] REF_CLOCKS_4 = 4'h4;
  localparam logic [3:0] REF_CLOCKS_6 = 4'h6;
  localparam logic [3:0] REF_CLOCKS_7 = 4'h7;
  localparam logic [3:0] REF_CLOCKS_8 = 4'h8;
  localparam logic [3:0] REF_PRE_SHORT = 4'h2;  // 3 phases in whole clocks
  localparam logic [3:0] REF_PRE_LONG = 4'h3;   // 5 phases in whole clocks
  localparam logic [3:0] REF_CAS_LEAD = 4'h1;

  // ==========================================================
  // precharge phases, page span, widths, sram cycle
  localparam logic [2:0] PHASES_SHORT = 3'h4;
  localparam logic [2:0] PHASES_LONG = 3'h6;
  localparam logic [2:0] PHASE_ONE = 3'h1;
  localparam logic [3:0] SPAN_LOG2_256 = 4'h8;
  localparam logic [3:0] SPAN_LOG2_512 = 4'h9;
  localparam logic [3:0] SPAN_LOG2_1K = 4'ha;
  localparam logic [3:0] SPAN_LOG2_2K = 4'hb;
  localparam logic [3:0] SPAN_LOG2_4K = 4'hc;
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_RSVD = 2'h2;
  localparam logic [1:0] WIDTH_EXT_ACK = 2'h3;
  localparam logic [3:0] WAIT_ONE = 4'h1;
  localparam logic [4:0] SRAM_MIN_CLOCKS = 5'h03;
  localparam logic [4:0] SYNC_BASE_ADD = 5'h02;
  localparam logic [4:0] ASYNC_BASE_ADD = 5'h03;
  localparam logic [4:0] EXTRA_CLOCK = 5'h01;
  localparam logic [4:0] ASYNC_W1_EXTRA = 5'h05;

  typedef enum logic [1:0] {REF_IDLE, REF_PRECHARGE, REF_CAS, REF_RAS} refresh_state_type;

endpackage

// ===== refresh_timer.sv
`timescale 1ns/1ns

// divides the clock by 16 and counts interval+1 of those steps
module refresh_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [mem_cfg_pkg::INTERVAL_W-1:0] interval,
  output logic tick
);

  logic [3:0] prescale_reg;
  logic [mem_cfg_pkg::INTERVAL_W-1:0] count_reg;
  logic [3:0] prescale_next;
  logic [mem_cfg_pkg::INTERVAL_W-1:0] count_next;
  logic tick_next;
  logic step;
  logic expire;

  // ==========================================================
  // next-state terms
  assign step = enable & (prescale_reg == mem_cfg_pkg::PRESCALE_LAST);
  assign expire = step & (count_reg == interval);
  assign prescale_next = enable ? prescale_reg + 4'h1 : 4'h0;
  // counting up against the live interval keeps the first period whole,
  // even when enable and a new interval arrive in the same write
  assign count_next = (!enable || expire) ? '0
                    : (step ? count_reg + 8'h01 : count_reg);
  assign tick_next = expire;

  // counters
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_reg <= 4'h0;
      count_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_next;
      count_reg <= count_next;
      tick <= tick_next;
    end
  end

endmodule // refresh_timer

// ===== memory_ctrl_global_config.sv
`timescale 1ns/1ns

// Summary of operation
// - refresh period is (interval+1) steps of system clock divided by 16.
// - refresh cycles happen only while refresh_on is set.
// - refresh_length picks 4/6/7/8 clocks and 3 or 5 RAS-off phases.
// - page_span picks 256/512/1024/2048/4096 address page compare size.
// - dram_width_sel picks 32-bit, 16-bit, reserved, or external acknowledge.
// - burst master on 32/16-bit bank ends with transfer_ack, not port_size_ack.
// - burst master precharge 4 or 6 phases, one less with late strobe.
// - late strobe phase saving applies only to back-to-back DRAM cycles.
// - native masters precharge 4 or 6 phases, one less in page mode.
// - page_write_delay adds a clock to native-master page-hit writes on wait-one banks.
// - sram_write_delay_ext adds a wait to burst master non-DRAM writes.
// - ext_master_sram_wait adds a wait only while ext_synchronous is clear.
// - non-burst SRAM cycle clocks follow the sync/async wait table.
// - async mode ties SRAM select and ack to address_strobe, ignores attributes.
// - async mode negates DRAM CAS and ack following address_strobe negation.
// - refresh RAS and CAS are always driven from the system clock.
// - sync mode negates DRAM CAS and ack on the system clock.
// - late_strobe_sample delays select/RAS a phase and adds a clock for burst masters.
module memory_ctrl_global_config (
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mem_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // current access attributes
  input wire logic extBurstMaster,
  input wire logic dramBank,
  input wire logic cycleWrite,
  input wire logic pageHit,
  input wire logic pageModeOn,
  input wire logic backToBack,
  input wire logic [3:0] cycleWaitCount,
  input wire logic busSyncTiming,
  input wire logic refreshGrant,
  // refresh engine
  output logic refreshReq,
  output logic refreshBusy,
  output logic refreshRasN,
  output logic refreshCasN,
  // decoded timing for the bank sequencers
  output logic [2:0] rasOffPhases,
  output logic pageWriteExtraClock,
  output logic sramWriteExtraWait,
  output logic [4:0] sramCycleClocks,
  output logic lateStrobeExtraClock,
  output logic [3:0] pageSpanLog2,
  output logic portIs16,
  output logic portSizeAckOn,
  output logic transferAckOn,
  output logic externalAckOn,
  output logic widthReserved,
  output logic strobeFollowMode,
  output logic attrIgnored,
  output logic oddParity,
  output logic parityBerrOn,
  output logic noCpuSpace,
  output logic globalAmuxOn
);

  // ==========================================================
  // decode helpers

  // ras negation phases: long or short base, one phase given back
  function automatic logic [2:0] offPhases(input logic longSel, input logic giveBack);
    logic [2:0] base;
    base = longSel ? mem_cfg_pkg::PHASES_LONG : mem_cfg_pkg::PHASES_SHORT;
    offPhases = giveBack ? base - mem_cfg_pkg::PHASE_ONE : base;
  endfunction

  // total refresh clocks for a length code
  function automatic logic [3:0] refreshClocks(input logic [1:0] code);
    case (code)
      mem_cfg_pkg::REF_LEN_4: refreshClocks = mem_cfg_pkg::REF_CLOCKS_4;
      mem_cfg_pkg::REF_LEN_6: refreshClocks = mem_cfg_pkg::REF_CLOCKS_6;
      mem_cfg_pkg::REF_LEN_7: refreshClocks = mem_cfg_pkg::REF_CLOCKS_7;
      default: refreshClocks = mem_cfg_pkg::REF_CLOCKS_8;
    endcase
  endfunction

  // ==========================================================
  // register and field views
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [mem_cfg_pkg::INTERVAL_W-1:0] refreshInterval;
  logic refreshOn;
  logic [1:0] refreshLength;
  logic [2:0] pageSpan;
  logic [1:0] dramWidthSel;
  logic prechargeExtBurst;
  logic prechargeNative;
  logic extSynchronous;
  logic extMasterSramWait;
  logic lateStrobeSample;
  logic pageWriteDelay;
  logic sramWriteDelayExt;

  assign refreshInterval = cfg_reg[mem_cfg_pkg::INTERVAL_LSB +: mem_cfg_pkg::INTERVAL_W];
  assign refreshOn = cfg_reg[mem_cfg_pkg::REFRESH_ON_BIT];
  assign refreshLength = cfg_reg[mem_cfg_pkg::REFRESH_LENGTH_LSB +: 2];
  assign pageSpan = cfg_reg[mem_cfg_pkg::PAGE_SPAN_LSB +: 3];
  assign dramWidthSel = cfg_reg[mem_cfg_pkg::DRAM_WIDTH_LSB +: 2];
  assign prechargeExtBurst = cfg_reg[mem_cfg_pkg::PRECHARGE_EXT_BIT];
  assign prechargeNative = cfg_reg[mem_cfg_pkg::PRECHARGE_NATIVE_BIT];
  assign extSynchronous = cfg_reg[mem_cfg_pkg::EXT_SYNC_BIT];
  assign extMasterSramWait = cfg_reg[mem_cfg_pkg::EXT_SRAM_WAIT_BIT];
  assign lateStrobeSample = cfg_reg[mem_cfg_pkg::LATE_STROBE_BIT];
  assign pageWriteDelay = cfg_reg[mem_cfg_pkg::PAGE_WRITE_DELAY_BIT];
  assign sramWriteDelayExt = cfg_reg[mem_cfg_pkg::SRAM_WRITE_DELAY_BIT];

  // ==========================================================
  // apb decode: no wait state, answer in the first access cycle
  logic setupPhase;
  logic accessDone;
  logic hitCfg;
  logic hitStatus;
  logic cfgWrite;
  logic [31:0] statusValue;
  logic [31:0] readValue;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign hitCfg = (paddr == mem_cfg_pkg::CFG_OFFSET);
  assign hitStatus = (paddr == mem_cfg_pkg::STATUS_OFFSET);
  assign cfgWrite = accessDone & pwrite & hitCfg;
  // reserved low bits are masked so they never store
  assign cfg_next = cfgWrite ? (pwdata & mem_cfg_pkg::CFG_WRITE_MASK) : cfg_reg;
  assign readValue = hitCfg ? cfg_reg : (hitStatus ? statusValue : 32'h0000_0000);

  // bus answer flops; unmapped addresses answer with pslverr
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~(hitCfg | hitStatus);
      prdata <= setupPhase ? readValue : prdata;
    end
  end

  // configuration word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= mem_cfg_pkg::CFG_RESET;
    else
      cfg_reg <= cfg_next;
  end

  // ==========================================================
  // refresh timer and request stack
  logic refreshTick;

  refresh_timer i_refresh_timer (
    .clock(clock),
    .rst_n(rst_n),
    .enable(refreshOn),
    .interval(refreshInterval),
    .tick(refreshTick)
  );

  mem_cfg_pkg::refresh_state_type state_reg;
  mem_cfg_pkg::refresh_state_type state_next;
  logic [3:0] stepCount_reg;
  logic [3:0] stepCount_next;
  logic [2:0] pending_reg;
  logic [2:0] pending_next;
  logic startRefresh;
  logic pushRequest;
  logic [3:0] totalClocks;
  logic [3:0] prechargeClocks;
  logic [3:0] rasClocks;

  // requests stack up to seven while the bus is not granted
  assign startRefresh = (state_reg == mem_cfg_pkg::REF_IDLE) & refreshReq & refreshGrant;
  assign pushRequest = refreshTick & refreshOn & (pending_reg != mem_cfg_pkg::PENDING_MAX);
  // a tick in the same cycle as a start keeps the count, so no request is lost unless seven are already pending
  assign pending_next = !refreshOn ? 3'h0
                      : (pushRequest && !startRefresh) ? pending_reg + 3'h1
                      : (startRefresh && !pushRequest) ? pending_reg - 3'h1
                      : pending_reg;

  assign totalClocks = refreshClocks(refreshLength);
  assign prechargeClocks = (refreshLength == mem_cfg_pkg::REF_LEN_4)
                         ? mem_cfg_pkg::REF_PRE_SHORT : mem_cfg_pkg::REF_PRE_LONG;
  assign rasClocks = totalClocks - prechargeClocks - mem_cfg_pkg::REF_CAS_LEAD;

  // cas-before-ras sequence: precharge, cas alone, then ras with cas
  always_comb
  begin
    state_next = state_reg;
    stepCount_next = stepCount_reg;
    case (state_reg)
      mem_cfg_pkg::REF_IDLE:
      begin
        if (startRefresh)
        begin
          state_next = mem_cfg_pkg::REF_PRECHARGE;
          stepCount_next = prechargeClocks - 4'h1;
        end
      end
      mem_cfg_pkg::REF_PRECHARGE:
      begin
        if (stepCount_reg == 4'h0)
          state_next = mem_cfg_pkg::REF_CAS;
        else
          stepCount_next = stepCount_reg - 4'h1;
      end
      mem_cfg_pkg::REF_CAS:
      begin
        state_next = mem_cfg_pkg::REF_RAS;
        stepCount_next = rasClocks - 4'h1;
      end
      mem_cfg_pkg::REF_RAS:
      begin
        if (stepCount_reg == 4'h0)
          state_next = mem_cfg_pkg::REF_IDLE;
        else
          stepCount_next = stepCount_reg - 4'h1;
      end
      default:
      begin
        state_next = mem_cfg_pkg::REF_IDLE;
        stepCount_next = 4'h0;
      end
    endcase
  end

  // strobes are plain flops on the system clock, never on a master strobe
  logic rasN_next;
  logic casN_next;
  assign rasN_next = (state_next != mem_cfg_pkg::REF_RAS);
  assign casN_next = ~((state_next == mem_cfg_pkg::REF_CAS) | (state_next == mem_cfg_pkg::REF_RAS));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= mem_cfg_pkg::REF_IDLE;
      stepCount_reg <= 4'h0;
      pending_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      stepCount_reg <= stepCount_next;
      pending_reg <= pending_next;
    end
  end

  // refresh outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshReq <= 1'b0;
      refreshBusy <= 1'b0;
      refreshRasN <= 1'b1;
      refreshCasN <= 1'b1;
    end
    else
    begin
      refreshReq <= refreshOn & (pending_next != 3'h0);
      refreshBusy <= (state_next != mem_cfg_pkg::REF_IDLE);
      refreshRasN <= rasN_next;
      refreshCasN <= casN_next;
    end
  end

  assign statusValue = {27'h0000000, refreshBusy, 1'b0, pending_reg};

  // ==========================================================
  // bank timing decode
  logic [2:0] phases_next;
  logic pageWrite_next;
  logic sramWrite_next;
  logic emwsEffective;
  logic [4:0] sramClocks_next;
  logic [4:0] waitWide;
  logic [3:0] span_next;
  logic burstOnBank;

  // burst master gets a phase back only between back-to-back cycles
  assign phases_next = extBurstMaster
                     ? offPhases(prechargeExtBurst, lateStrobeSample & backToBack)
                     : offPhases(prechargeNative, pageModeOn);

  // page-hit writes by native masters on wait-one banks
  assign pageWrite_next = pageWriteDelay & dramBank & cycleWrite & pageHit
                        & ~extBurstMaster & (cycleWaitCount == mem_cfg_pkg::WAIT_ONE);
  assign sramWrite_next = sramWriteDelayExt & extBurstMaster & cycleWrite & ~dramBank;

  // the extra wait only counts for asynchronous masters
  assign emwsEffective = extMasterSramWait & ~extSynchronous;
  assign waitWide = {1'b0, cycleWaitCount};

  // non-burst external master sram cycle length
  always_comb
  begin
    sramClocks_next = mem_cfg_pkg::SRAM_MIN_CLOCKS;
    if (cycleWaitCount == 4'h0)
      sramClocks_next = mem_cfg_pkg::SRAM_MIN_CLOCKS;
    else if (cycleWaitCount == mem_cfg_pkg::WAIT_ONE)
    begin
      if (emwsEffective)
        sramClocks_next = busSyncTiming ? mem_cfg_pkg::SRAM_MIN_CLOCKS + mem_cfg_pkg::EXTRA_CLOCK
                                        : mem_cfg_pkg::ASYNC_W1_EXTRA;
    end
    else
    begin
      sramClocks_next = waitWide + (busSyncTiming ? mem_cfg_pkg::SYNC_BASE_ADD
                                                  : mem_cfg_pkg::ASYNC_BASE_ADD);
      if (emwsEffective)
        sramClocks_next = sramClocks_next + mem_cfg_pkg::EXTRA_CLOCK;
    end
  end

  // page compare span; the last duplicated code, 110, is read as 101
  always_comb
  begin
    case (pageSpan)
      3'h0: span_next = mem_cfg_pkg::SPAN_LOG2_256;
      3'h1, 3'h2: span_next = mem_cfg_pkg::SPAN_LOG2_512;
      3'h3, 3'h4: span_next = mem_cfg_pkg::SPAN_LOG2_1K;
      3'h5, 3'h6: span_next = mem_cfg_pkg::SPAN_LOG2_2K;
      default: span_next = mem_cfg_pkg::SPAN_LOG2_4K;
    endcase
  end

  // the controller terminates only 32- and 16-bit banks itself
  assign burstOnBank = (dramWidthSel == mem_cfg_pkg::WIDTH_32) | (dramWidthSel == mem_cfg_pkg::WIDTH_16);

  // timing outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rasOffPhases <= mem_cfg_pkg::PHASES_SHORT;
      pageWriteExtraClock <= 1'b0;
      sramWriteExtraWait <= 1'b0;
      sramCycleClocks <= mem_cfg_pkg::SRAM_MIN_CLOCKS;
      lateStrobeExtraClock <= 1'b0;
      pageSpanLog2 <= mem_cfg_pkg::SPAN_LOG2_256;
    end
    else
    begin
      rasOffPhases <= phases_next;
      pageWriteExtraClock <= pageWrite_next;
      sramWriteExtraWait <= sramWrite_next;
      sramCycleClocks <= sramClocks_next;
      lateStrobeExtraClock <= lateStrobeSample & extBurstMaster;
      pageSpanLog2 <= span_next;
    end
  end

  // acknowledge and strobe mode outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portIs16 <= 1'b0;
      portSizeAckOn <= 1'b0;
      transferAckOn <= 1'b0;
      externalAckOn <= 1'b0;
      widthReserved <= 1'b0;
      strobeFollowMode <= 1'b0;
      attrIgnored <= 1'b0;
    end
    else
    begin
      portIs16 <= (dramWidthSel == mem_cfg_pkg::WIDTH_16);
      portSizeAckOn <= burstOnBank & ~extBurstMaster;
      transferAckOn <= burstOnBank & extBurstMaster;
      externalAckOn <= (dramWidthSel == mem_cfg_pkg::WIDTH_EXT_ACK);
      widthReserved <= (dramWidthSel == mem_cfg_pkg::WIDTH_RSVD);
      // async: select, cas and ack negation follow address_strobe
      strobeFollowMode <= ~extSynchronous;
      attrIgnored <= ~extSynchronous;
    end
  end

  // pass-through attribute bits used by parity and address logic
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oddParity <= 1'b0;
      parityBerrOn <= 1'b0;
      noCpuSpace <= 1'b0;
      globalAmuxOn <= 1'b0;
    end
    else
    begin
      oddParity <= cfg_reg[mem_cfg_pkg::ODD_PARITY_BIT];
      parityBerrOn <= cfg_reg[mem_cfg_pkg::PARITY_BERR_BIT];
      noCpuSpace <= cfg_reg[mem_cfg_pkg::NO_CPU_SPACE_BIT];
      globalAmuxOn <= cfg_reg[mem_cfg_pkg::GLOBAL_AMUX_BIT];
    end
  end

endmodule // memory_ctrl_global_config

// ===== mcgc_props.sv
`timescale 1ns/1ns
// ==========
// port checker
module mcgc_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mem_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic extBurstMaster,
  input wire logic dramBank,
  input wire logic cycleWrite,
  input wire logic pageHit,
  input wire logic pageModeOn,
  input wire logic [3:0] cycleWaitCount,
  input wire logic refreshBusy,
  input wire logic refreshRasN,
  input wire logic refreshCasN,
  input wire logic [2:0] rasOffPhases,
  input wire logic pageWriteExtraClock,
  input wire logic sramWriteExtraWait,
  input wire logic portSizeAckOn
);
  // single domain, so one clocking and one reset
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_rsvd; pready && !pwrite && paddr == 12'h000 |-> prdata[4:0] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_cbr; $rose(refreshBusy) |-> refreshRasN && refreshCasN ##1 refreshRasN && refreshCasN; endproperty
  a_cbr: assert property (p_cbr) else $error("short precharge");
  property p_cas; $fell(refreshRasN) |-> !refreshCasN && $past(refreshCasN) == 1'b0; endproperty
  a_cas: assert property (p_cas) else $error("ras before cas");
  property p_pwd; !(dramBank && cycleWrite && pageHit && !extBurstMaster && cycleWaitCount == 4'h1)
    |=> !pageWriteExtraClock; endproperty
  a_pwd: assert property (p_pwd) else $error("stray write delay");
  property p_swd; !(extBurstMaster && !dramBank && cycleWrite) |=> !sramWriteExtraWait; endproperty
  a_swd: assert property (p_swd) else $error("stray sram wait");
  property p_ta; extBurstMaster && dramBank |=> !portSizeAckOn; endproperty
  a_ta: assert property (p_ta) else $error("burst got size ack");
  property p_pre; !extBurstMaster && !pageModeOn |=> rasOffPhases inside {3'h4, 3'h6}; endproperty
  a_pre: assert property (p_pre) else $error("bad precharge");
  // main scenarios reached
  c_ref: cover property ($fell(refreshRasN));
  c_pwd: cover property (pageWriteExtraClock);
  c_swd: cover property (sramWriteExtraWait);
endmodule // mcgc_props

// ===== bank_model.sv
`timescale 1ns/1ns
// ==========
// dram side: grants refresh, times each refresh cycle
module bank_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic grantOn,
  input wire logic refreshReq,
  input wire logic refreshBusy,
  input wire logic refreshRasN,
  output logic refreshGrant,
  output int busyLen,
  output int rasLen,
  output int refCount
);
  int busyCnt;
  int rasCnt;
  // grant lags a clock like a slow arbiter; never acks on its own
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshGrant <= 1'b0;
      busyCnt <= 0;
      rasCnt <= 0;
      refCount <= 0;
    end
    else
    begin
      refreshGrant <= refreshReq && grantOn;
      busyCnt <= refreshBusy ? busyCnt + 1 : 0;
      rasCnt <= refreshBusy ? rasCnt + int'(!refreshRasN) : 0;
      if (!refreshBusy && busyCnt != 0)
      begin
        busyLen <= busyCnt;
        rasLen <= rasCnt;
        refCount <= refCount + 1;
      end
    end
  end
endmodule // bank_model

// ===== memory_ctrl_global_config_test.sv
`timescale 1ns/1ns
// ==========
// self-checking bench
module memory_ctrl_global_config_test;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, grantOn = 1'b0;
  logic extBurstMaster = 1'b0, dramBank = 1'b0, cycleWrite = 1'b0, pageHit = 1'b0, err;
  logic pageModeOn = 1'b0, backToBack = 1'b0, busSyncTiming = 1'b0, refreshGrant, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] cycleWaitCount = 4'h0, pageSpanLog2;
  logic [2:0] rasOffPhases;
  logic [4:0] sramCycleClocks;
  logic refreshReq, refreshBusy, refreshRasN, refreshCasN, pageWriteExtraClock, sramWriteExtraWait;
  logic lateStrobeExtraClock, portIs16, portSizeAckOn, transferAckOn, externalAckOn, widthReserved;
  logic strobeFollowMode, attrIgnored, oddParity, parityBerrOn, noCpuSpace, globalAmuxOn;
  int fails = 0, cmp_count = 0, busyLen, rasLen, refCount;
  // 125 MHz
  always #4 clock = ~clock;
  memory_ctrl_global_config i_memory_ctrl_global_config (.*);
  bank_model i_bank_model (.*);
  // ==========
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      conclude();
    end
    @(posedge clock);
  endtask
  // decode lags a clock, so let two edges pass
  task automatic s;
    repeat (2) @(posedge clock);
  endtask
  task automatic wref(output int n);
    int k;
    k = refCount;
    n = 0;
    while (refCount == k && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    if (refCount == k)
    begin
      fails++;
      conclude();
    end
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0000_1200);
    cmp({oddParity, parityBerrOn, noCpuSpace, globalAmuxOn}, 4'h0);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'hffff_ffe0);
    cmp({oddParity, parityBerrOn, noCpuSpace, globalAmuxOn}, 4'hf);
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd, 32'h0);
    cmp(err, 1'b1);
  endtask
  task automatic t_decode;
    logic [3:0] lg [8] = '{4'h8, 4'h9, 4'h9, 4'ha, 4'ha, 4'hb, 4'hb, 4'hc};
    dramBank <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, 12'h000, 32'(c) << 18 | 32'(c[1:0]) << 16);
      extBurstMaster <= c[2];
      s();
      cmp(pageSpanLog2, lg[c]);
      cmp({portIs16, widthReserved, externalAckOn}, {c[1:0] == 2'h1, c[1:0] == 2'h2, c[1:0] == 2'h3});
      cmp({transferAckOn, portSizeAckOn}, {c[2], !c[2]} & {2{c[1:0] < 2'h2}});
    end
  endtask
  task automatic t_pre;
    logic [15:0] cf [9] = '{16'h0, 16'h80, 16'h4000, 16'h4080, 16'h0, 16'h200, 16'h200, 16'h8200, 16'h8000};
    logic [2:0] in [9] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h4, 3'h6, 3'h4, 3'h6, 3'h4};
    logic [2:0] ex [9] = '{3'h4, 3'h3, 3'h6, 3'h5, 3'h4, 3'h3, 3'h4, 3'h5, 3'h6};
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 12'h000, 32'(cf[i]));
      {extBurstMaster, backToBack, pageModeOn} <= in[i];
      s();
      cmp(rasOffPhases, ex[i]);
      cmp(lateStrobeExtraClock, cf[i][9] & in[i][2]);
    end
  endtask
  task automatic t_waits;
    logic [8:0] cs [7] = '{9'h139, 9'h13a, 9'h039, 9'h129, 9'h0d0, 9'h0c0, 9'h050};
    logic [1:0] ex [7] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    pageModeOn <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, 12'h000, 32'(cs[i][8:7]) << 6);
      {extBurstMaster, dramBank, cycleWrite, pageHit} <= cs[i][6:3];
      cycleWaitCount <= {2'h0, cs[i][1:0]};
      s();
      cmp({pageWriteExtraClock, sramWriteExtraWait}, ex[i]);
    end
  endtask
  task automatic t_sram;
    logic [6:0] cs [10] = '{7'h10, 7'h11, 7'h12, 7'h1f, 7'h01, 7'h02, 7'h22, 7'h2f, 7'h72, 7'h31};
    logic [4:0] ex [10] = '{5'h03, 5'h05, 5'h06, 5'h13, 5'h03, 5'h05, 5'h04, 5'h11, 5'h04, 5'h04};
    {extBurstMaster, dramBank, cycleWrite} <= 3'h0;
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, 12'h000, 32'({cs[i][6], cs[i][4]}) << 12);
      busSyncTiming <= cs[i][5];
      cycleWaitCount <= cs[i][3:0];
      s();
      cmp(sramCycleClocks, ex[i]);
      cmp({strobeFollowMode, attrIgnored}, {2{!cs[i][6]}});
    end
  endtask
  // interval 1 gives 32 clocks between refreshes
  task automatic t_refresh;
    int n;
    int k;
    logic [3:0] len [4] = '{4'h4, 4'h6, 4'h7, 4'h8};
    grantOn <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, 12'h000, 32'h0180_0000 | 32'(c) << 21);
      wref(n);
      wref(n);
      cmp(n, 32);
      cmp(busyLen, len[c]);
      cmp(rasLen, len[c] - (c == 0 ? 3 : 4));
    end
    apb(1'b1, 12'h000, 32'h0100_0000);
    k = refCount;
    repeat (80) @(posedge clock);
    cmp(refCount, k);
    cmp(refreshReq, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd, 32'h0);
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_decode();
    t_pre();
    t_waits();
    t_sram();
    t_refresh();
    conclude();
  end
endmodule // memory_ctrl_global_config_test
bind memory_ctrl_global_config mcgc_props i_mcgc_props (.*);
